// file: hw/wtu_wake_timer.sv
`timescale 1ns/1ps
// Functional notes
// - entering sleep clears modem configuration registers; restore after wake.
// - counter decrements per prescaler tick; code 0..7 selects divide 1..65536.
// - upper reload byte held pending until lower reload byte written.
// - armed counter reaching zero raises wake-up event.
// - lower config bit4 clock source, bit6 rc enable, bit5 crystal enable.
// - lower config bit3 keeps backup memory powered in sleep.
// - lower config bit0 arms wake-up on timeout.
// - flag-clear bit0 clears latched timeout and cold-start flags.
// - flag-clear bit1 enables rc oscillator calibration.
// - status bit6 calibration fault, bit5 calibration done.
// - status bit4 crystal settled, valid while crystal enabled.
// - status bit3 live crystal output level.
// - status bit2 cold start seen, sticky until cleared.
// - status bit1 latched timeout, sticky until cleared.
// - status bit0 live counter-at-zero indication.
module wtu_wake_timer (
	input wire logic sys_clk, // system clock 100 MHz
	input wire logic nrst, // async reset, active low
	input wire logic [9:0] regAddr, // register address
	input wire logic [7:0] regWdata, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [7:0] regRdata, // read data, cycle after strobe
	input wire logic rcTick, // rc oscillator 32.768 kHz clock pin
	input wire logic xoscTick, // crystal oscillator 32.768 kHz clock pin
	input wire logic xoscSettled, // crystal settled indication pin
	input wire logic calFault, // calibration fault pin from rc trim
	output logic wakeEvent, // one-cycle wake-up pulse
	output logic rcOscEnable, // rc oscillator enable
	output logic crystalOscEnable, // crystal oscillator enable
	output logic backupMemPowerKeep, // keep backup memory powered
	output logic sleepState // chip in sleep state
);
	logic rstSync1_r, rstSync2_r, rstN;
	logic [2:0] rcSync_r, xoSync_r;
	logic [1:0] setSync_r, calfSync_r;
	logic [7:0] cfgUpper_r, cfgLower_r, reloadUpperPend_r, modemCfg_r;
	logic [15:0] reload_r, count_r, presc_r;
	logic [6:0] calCnt_r;
	logic calEnable_r, calFault_r, coldStart_r, timeoutLatched_r, sleep_r;
	logic srcEdge, presTick, atZero, wrUpper, wrLower, wrRelU, wrRelL, wrClear;
	wtu_pkg::wtu_cal_t calState_r;

	function automatic logic [16:0] divFor(input logic [2:0] code);
		case (code)
			3'h0: divFor = {1'b0, wtu_pkg::DIV_CODE0};
			3'h1: divFor = {1'b0, wtu_pkg::DIV_CODE1};
			3'h2: divFor = {1'b0, wtu_pkg::DIV_CODE2};
			3'h3: divFor = {1'b0, wtu_pkg::DIV_CODE3};
			3'h4: divFor = {1'b0, wtu_pkg::DIV_CODE4};
			3'h5: divFor = {1'b0, wtu_pkg::DIV_CODE5};
			3'h6: divFor = {1'b0, wtu_pkg::DIV_CODE6};
			default: divFor = wtu_pkg::DIV_CODE7;
		endcase
	endfunction

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end
		else
		begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end
	assign rstN = rstSync2_r;

	// third stage only feeds edge detection, never the first flop
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rcSync_r <= 3'h0;
			xoSync_r <= 3'h0;
			setSync_r <= 2'h0;
			calfSync_r <= 2'h0;
		end
		else
		begin
			rcSync_r <= {rcSync_r[1:0], rcTick};
			xoSync_r <= {xoSync_r[1:0], xoscTick};
			setSync_r <= {setSync_r[0], xoscSettled};
			calfSync_r <= {calfSync_r[0], calFault};
		end
	end

	assign wrUpper = regWr && regAddr == wtu_pkg::CFG_UPPER_OFF;
	assign wrLower = regWr && regAddr == wtu_pkg::CFG_LOWER_OFF;
	assign wrRelU = regWr && regAddr == wtu_pkg::RELOAD_UPPER_OFF;
	assign wrRelL = regWr && regAddr == wtu_pkg::RELOAD_LOWER_OFF;
	assign wrClear = regWr && regAddr == wtu_pkg::FLAG_CLEAR_OFF;

	// lower config assumed written after upper; no ordering check in hardware
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			cfgUpper_r <= wtu_pkg::REG_RESET;
			cfgLower_r <= wtu_pkg::REG_RESET;
		end
		else
		begin
			if (wrUpper)
				cfgUpper_r <= regWdata;
			if (wrLower)
				cfgLower_r <= regWdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			reloadUpperPend_r <= wtu_pkg::REG_RESET;
			reload_r <= {wtu_pkg::REG_RESET, wtu_pkg::REG_RESET};
		end
		else
		begin
			if (wrRelU)
				reloadUpperPend_r <= regWdata;
			if (wrRelL)
				reload_r <= {reloadUpperPend_r, regWdata};
		end
	end

	// modem configuration and sleep control; sleep wipes the modem settings
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			modemCfg_r <= wtu_pkg::REG_RESET;
			sleep_r <= 1'b0;
		end
		else
		begin
			if (regWr && regAddr == wtu_pkg::SLEEP_CTRL_OFF)
				sleep_r <= regWdata[0];
			else if (wakeEvent)
				sleep_r <= 1'b0;
			if (sleep_r)
				modemCfg_r <= wtu_pkg::REG_RESET;
			else if (regWr && regAddr == wtu_pkg::SLEEP_CTRL_OFF + 10'h001)
				modemCfg_r <= regWdata;
		end
	end

	assign srcEdge = cfgLower_r[wtu_pkg::CLKSEL_BIT] ?
		(rcSync_r[1] & ~rcSync_r[2] & cfgLower_r[wtu_pkg::RCOSC_EN_BIT]) :
		(xoSync_r[1] & ~xoSync_r[2] & cfgLower_r[wtu_pkg::XOSC_EN_BIT]);

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			presc_r <= 16'h0000;
		else if (srcEdge)
		begin
			if ({1'b0, presc_r} + 17'h00001 >= divFor(cfgUpper_r[2:0]))
				presc_r <= 16'h0000;
			else
				presc_r <= presc_r + 16'h0001;
		end
	end
	assign presTick = srcEdge &&
		({1'b0, presc_r} + 17'h00001 >= divFor(cfgUpper_r[2:0]));

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			count_r <= 16'h0000;
		else if (wrRelL)
			count_r <= {reloadUpperPend_r, regWdata};
		else if (presTick)
		begin
			if (count_r == 16'h0000)
				count_r <= reload_r;
			else
				count_r <= count_r - 16'h0001;
		end
	end
	assign atZero = count_r == 16'h0000;

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			wakeEvent <= 1'b0;
		else
			wakeEvent <= presTick && count_r == 16'h0001 &&
				cfgLower_r[wtu_pkg::ARM_BIT];
	end

	// set wins over clear for the timeout flag; cold start is set only by reset
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			coldStart_r <= 1'b1;
			timeoutLatched_r <= 1'b0;
		end
		else
		begin
			if (wrClear && regWdata[wtu_pkg::CLR_BIT])
				coldStart_r <= 1'b0;
			if (presTick && count_r == 16'h0001)
				timeoutLatched_r <= 1'b1;
			else if (wrClear && regWdata[wtu_pkg::CLR_BIT])
				timeoutLatched_r <= 1'b0;
		end
	end

	// calibration runs a fixed cycle budget; fault sampled from pin at end
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			calEnable_r <= 1'b0;
			calState_r <= wtu_pkg::CAL_IDLE;
			calCnt_r <= 7'h00;
			calFault_r <= 1'b0;
		end
		else
		begin
			if (wrClear)
				calEnable_r <= regWdata[wtu_pkg::CAL_EN_BIT];
			case (calState_r)
				wtu_pkg::CAL_IDLE:
				begin
					if (calEnable_r)
					begin
						calState_r <= wtu_pkg::CAL_RUN;
						calCnt_r <= 7'h00;
						calFault_r <= 1'b0;
					end
				end
				wtu_pkg::CAL_RUN:
				begin
					if (!calEnable_r)
						calState_r <= wtu_pkg::CAL_IDLE;
					else if (calCnt_r == wtu_pkg::CAL_COUNT - 7'h01)
					begin
						calState_r <= wtu_pkg::CAL_DONE;
						calFault_r <= calfSync_r[1];
					end
					else
						calCnt_r <= calCnt_r + 7'h01;
				end
				wtu_pkg::CAL_DONE:
				begin
					if (!calEnable_r)
						calState_r <= wtu_pkg::CAL_IDLE;
				end
				default: calState_r <= wtu_pkg::CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			regRdata <= 8'h00;
		else if (regRd)
		begin
			case (regAddr)
				wtu_pkg::FLAG_CLEAR_OFF: regRdata <= {6'h00, calEnable_r, 1'b0};
				wtu_pkg::STATE_OFF: regRdata <= {1'b0,
					calEnable_r & calFault_r,
					calEnable_r & (calState_r == wtu_pkg::CAL_DONE),
					cfgLower_r[wtu_pkg::XOSC_EN_BIT] & setSync_r[1],
					xoSync_r[1],
					coldStart_r,
					timeoutLatched_r,
					atZero};
				default: regRdata <= 8'h00;
			endcase
		end
		else
			regRdata <= 8'h00;
	end

	assign rcOscEnable = cfgLower_r[wtu_pkg::RCOSC_EN_BIT];
	assign crystalOscEnable = cfgLower_r[wtu_pkg::XOSC_EN_BIT];
	assign backupMemPowerKeep = cfgLower_r[wtu_pkg::BACKUP_BIT];
	assign sleepState = sleep_r;
endmodule // wtu_wake_timer

// file: pkg/wtu_pkg.sv
package wtu_pkg;
	localparam logic [9:0] CFG_UPPER_OFF = 10'h30c;
	localparam logic [9:0] CFG_LOWER_OFF = 10'h30d;
	localparam logic [9:0] RELOAD_UPPER_OFF = 10'h30e;
	localparam logic [9:0] RELOAD_LOWER_OFF = 10'h30f;
	localparam logic [9:0] FLAG_CLEAR_OFF = 10'h310;
	localparam logic [9:0] STATE_OFF = 10'h311;
	localparam logic [9:0] SLEEP_CTRL_OFF = 10'h3f0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int PRESC_LSB = 0;
	localparam int ARM_BIT = 0;
	localparam int BACKUP_BIT = 3;
	localparam int CLKSEL_BIT = 4;
	localparam int XOSC_EN_BIT = 5;
	localparam int RCOSC_EN_BIT = 6;
	localparam int CLR_BIT = 0;
	localparam int CAL_EN_BIT = 1;
	localparam int CAL_CYCLES = 64;
	localparam logic [6:0] CAL_COUNT = 7'h40;
	localparam logic [15:0] DIV_CODE0 = 16'h0001;
	localparam logic [15:0] DIV_CODE1 = 16'h0004;
	localparam logic [15:0] DIV_CODE2 = 16'h0008;
	localparam logic [15:0] DIV_CODE3 = 16'h0010;
	localparam logic [15:0] DIV_CODE4 = 16'h0080;
	localparam logic [15:0] DIV_CODE5 = 16'h0400;
	localparam logic [15:0] DIV_CODE6 = 16'h2000;
	localparam logic [16:0] DIV_CODE7 = 17'h10000;
	typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} wtu_cal_t;
endpackage

// file: tb/wtu_wake_timer_assertions.sv
`timescale 1ns/1ps
module wtu_wake_timer_assertions (
	input wire logic sys_clk, // clock
	input wire logic nrst, // reset, active low
	input wire logic [9:0] regAddr, // address
	input wire logic [7:0] regWdata, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	input wire logic [7:0] regRdata, // read data
	input wire logic wakeEvent, // wake pulse
	input wire logic rcOscEnable, // rc enable
	input wire logic crystalOscEnable, // crystal enable
	input wire logic backupMemPowerKeep, // backup power
	input wire logic sleepState // sleep state
);
	logic armR;
	logic cfgWr;
	assign cfgWr = regWr && regAddr == wtu_pkg::CFG_LOWER_OFF;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			armR <= 1'b0;
		else if (cfgWr)
			armR <= regWdata[wtu_pkg::ARM_BIT];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_cfg_enables: assert property (cfgWr |=> {rcOscEnable, crystalOscEnable} ==
		$past(regWdata[6:5])) else $error("enables differ from config");
	a_backup_keep: assert property (cfgWr |=> backupMemPowerKeep == $past(regWdata[3]))
		else $error("backup keep differs from config");
	a_enable_hold: assert property (!cfgWr |=> $stable({rcOscEnable, backupMemPowerKeep}))
		else $error("enables moved without write");
	a_wake_pulse: assert property (wakeEvent |=> !wakeEvent)
		else $error("wake longer than one cycle");
	a_wake_armed: assert property (wakeEvent |-> $past(armR))
		else $error("wake while not armed");
	a_wake_sleep: assert property (wakeEvent && !regWr |=> !sleepState)
		else $error("sleep kept after wake");
	a_reload_wo: assert property (regRd && regAddr inside {[10'h30c:10'h30f]} |=>
		regRdata == 8'h00) else $error("write-only place read nonzero");
	a_xosc_gate: assert property (regRd && regAddr == wtu_pkg::STATE_OFF &&
		!crystalOscEnable |=> !regRdata[4]) else $error("settled shown while disabled");
	a_rd_idle: assert property (!regRd |=> regRdata == 8'h00)
		else $error("read data outside read slot");
endmodule // wtu_wake_timer_assertions
bind wtu_wake_timer wtu_wake_timer_assertions wtu_wake_timer_assertions_i (.sys_clk, .nrst,
	.regAddr, .regWdata, .regWr, .regRd, .regRdata, .wakeEvent, .rcOscEnable,
	.crystalOscEnable, .backupMemPowerKeep, .sleepState);

// file: tb/wtu_wake_timer_tb_top.sv
`timescale 1ns/1ps
module wtu_wake_timer_tb_top;
	logic sys_clk = 0, nrst = 0, regWr = 0, regRd = 0, rcTick = 0, xoscTick = 0;
	logic xoscSettled = 0, calFault = 0;
	logic [9:0] regAddr = '0;
	logic [7:0] regWdata = '0;
	logic [7:0] regRdata;
	logic wakeEvent, rcOscEnable, crystalOscEnable, backupMemPowerKeep, sleepState;
	int n_errors = 0, num_checks = 0, nWake = 0, w;
	// codes 6 and 7 would take too long at bench speed
	int dv[6] = '{1, 4, 8, 16, 128, 1024};
	wtu_wake_timer wtu_wake_timer_i (.sys_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .rcTick, .xoscTick, .xoscSettled, .calFault, .wakeEvent, .rcOscEnable,
		.crystalOscEnable, .backupMemPowerKeep, .sleepState);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (wakeEvent === 1'b1) nWake <= nWake + 1;
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [9:0] a, logic [7:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
		// let the write land before callers look at outputs
		#1;
	endtask
	task automatic rd(logic [9:0] a, logic [7:0] e);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	// slow edges so the pin synchronizer sees every one
	task automatic tick(int n, bit x);
		repeat (n)
		begin
			rcTick <= !x;
			xoscTick <= x;
			repeat (4) @(posedge sys_clk);
			rcTick <= 1'b0;
			xoscTick <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		// wake count settles in the edge's update phase
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		n_errors++;
		stop_test;
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(wtu_pkg::STATE_OFF, 8'h05);
		rd(wtu_pkg::CFG_UPPER_OFF, 8'h00);
		rd(wtu_pkg::RELOAD_LOWER_OFF, 8'h00);
		rd(10'h000, 8'h00);
		wr(wtu_pkg::FLAG_CLEAR_OFF, 8'h01);
		rd(wtu_pkg::STATE_OFF, 8'h01);
		$display("reset test done");
		wr(wtu_pkg::CFG_UPPER_OFF, 8'h00);
		wr(wtu_pkg::CFG_LOWER_OFF, 8'h59);
		chk({5'h0, rcOscEnable, crystalOscEnable, backupMemPowerKeep}, 8'h05);
		wr(wtu_pkg::RELOAD_UPPER_OFF, 8'h00);
		wr(wtu_pkg::RELOAD_LOWER_OFF, 8'h03);
		wr(wtu_pkg::RELOAD_UPPER_OFF, 8'h01);
		wr(wtu_pkg::SLEEP_CTRL_OFF, 8'h01);
		chk({7'h0, sleepState}, 8'h01);
		tick(3, 0);
		chk(8'(nWake), 8'h01);
		chk({7'h0, sleepState}, 8'h00);
		rd(wtu_pkg::STATE_OFF, 8'h03);
		tick(1, 0);
		rd(wtu_pkg::STATE_OFF, 8'h02);
		tick(3, 0);
		chk(8'(nWake), 8'h02);
		wr(wtu_pkg::FLAG_CLEAR_OFF, 8'h01);
		wr(wtu_pkg::CFG_UPPER_OFF, 8'h00);
		wr(wtu_pkg::CFG_LOWER_OFF, 8'h58);
		tick(4, 0);
		chk(8'(nWake), 8'h02);
		rd(wtu_pkg::STATE_OFF, 8'h03);
		$display("reload and arm test done");
		wr(wtu_pkg::CFG_UPPER_OFF, 8'h00);
		wr(wtu_pkg::CFG_LOWER_OFF, 8'h21);
		chk({6'h0, rcOscEnable, crystalOscEnable}, 8'h01);
		tick(4, 0);
		chk(8'(nWake), 8'h02);
		tick(4, 1);
		chk(8'(nWake), 8'h03);
		// this rising level is one more crystal edge: counter reloads from zero to 3
		xoscTick <= 1'b1;
		xoscSettled <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(wtu_pkg::STATE_OFF, 8'h1a);
		wr(wtu_pkg::CFG_UPPER_OFF, 8'h00);
		wr(wtu_pkg::CFG_LOWER_OFF, 8'h00);
		rd(wtu_pkg::STATE_OFF, 8'h0a);
		xoscTick <= 1'b0;
		xoscSettled <= 1'b0;
		calFault <= 1'b1;
		wr(wtu_pkg::FLAG_CLEAR_OFF, 8'h02);
		rd(wtu_pkg::FLAG_CLEAR_OFF, 8'h02);
		repeat (70) @(posedge sys_clk);
		rd(wtu_pkg::STATE_OFF, 8'h62);
		wr(wtu_pkg::FLAG_CLEAR_OFF, 8'h00);
		rd(wtu_pkg::STATE_OFF, 8'h02);
		calFault <= 1'b0;
		$display("oscillator and calibration test done");
		// timing taken between two wakes, so prescaler phase does not matter
		foreach (dv[k])
		begin
			wr(wtu_pkg::CFG_UPPER_OFF, 8'(k));
			wr(wtu_pkg::CFG_LOWER_OFF, 8'h59);
			wr(wtu_pkg::RELOAD_UPPER_OFF, 8'h00);
			wr(wtu_pkg::RELOAD_LOWER_OFF, 8'h01);
			w = nWake;
			for (int i = 0; i < 2 * dv[k] + 2 && nWake == w; i++) tick(1, 0);
			w = nWake;
			tick(2 * dv[k] - 1, 0);
			chk(8'(nWake - w), 8'h00);
			tick(1, 0);
			chk(8'(nWake - w), 8'h01);
		end
		$display("prescaler test done");
		stop_test;
	end
endmodule // wtu_wake_timer_tb_top
